// ---- src/ssdr_pkg.sv ----
package ssdr_pkg;
    // ************************************************************
    // status byte field positions
    // ************************************************************
    localparam int ST_OUT_EN = 0;      // safety outputs enabled
    localparam int ST_ACT_DET = 1;     // actuator detected
    localparam int ST_LOOP_OPEN = 3;   // feedback loop open or button not pressed
    localparam int ST_INPUTS_LIVE = 4; // both safety inputs live
    localparam int ST_LIMIT = 5;       // actuated in limit area
    localparam int ST_WARN = 6;        // error warning
    localparam int ST_FAULT = 7;       // error, outputs off
    // ************************************************************
    // warning and fault detail positions
    // ************************************************************
    localparam int DT_OUT_A = 0;       // output a fault
    localparam int DT_OUT_B = 1;       // output b fault
    localparam int DT_XWIRE = 2;       // cross-wire between outputs
    localparam int DT_TEMP = 3;        // overtemperature
    localparam int DT_ACTUATOR = 4;    // wrong or defective actuator (fault only)
    localparam int DT_INTERNAL = 5;    // internal fault
    localparam int DT_COMM = 6;        // gateway communication fault (warning only)
    localparam int DT_DISC = 6;        // discrepancy timeout (fault only)
    // ************************************************************
    // command byte field positions
    // ************************************************************
    localparam int CMD_DISC_ACK = 6;   // discrepancy acknowledge, falling edge
    localparam int CMD_FAULT_RST = 7;  // fault reset, falling edge
    // ************************************************************
    // timing
    // ************************************************************
    localparam longint CLK_HZ = 250_000_000;        // system clock rate
    localparam longint BLINK_HZ = 5;                // yellow blink rate
    localparam longint BLINK_HALF_CYC = CLK_HZ / (BLINK_HZ * 2); // half period cycles
    localparam longint DISC_MS = 500;               // discrepancy limit in ms
    localparam longint DISC_CYC = DISC_MS * (CLK_HZ / 1000);     // more than this trips
    localparam longint WARN_MIN = 30;               // warning timeout in minutes
    localparam longint WARN_CYC = WARN_MIN * 60 * CLK_HZ;        // cycles to trip
endpackage : ssdr_pkg

// ---- src/ssdr_core.sv ----
module ssdr_core #(
    parameter longint BLINK_HALF = ssdr_pkg::BLINK_HALF_CYC, // blink half period cycles
    parameter longint DISC_LIMIT = ssdr_pkg::DISC_CYC,       // discrepancy limit cycles
    parameter longint WARN_LIMIT = ssdr_pkg::WARN_CYC        // warning timeout cycles
) (
    input wire logic i_clk,                  // 250 MHz system clock
    input wire logic i_rst,                  // synchronous reset, active high
    input wire logic i_auto_release_variant, // strap: 1 automatic, 0 reset button
    input wire logic i_discrepancy_enable,   // strap: last sensor monitors inputs
    input wire logic i_safe_in_a,            // safety input a pin
    input wire logic i_safe_in_b,            // safety input b pin
    input wire logic i_feedback_closed,      // feedback loop closed pin
    input wire logic i_reset_button,         // monitored reset button pin
    input wire logic i_ack_button,           // discrepancy acknowledge button pin
    input wire logic i_actuator_detected,    // actuator in range, same clock
    input wire logic i_limit_area,           // actuated in limit area, same clock
    input wire logic i_actuator_bad,         // wrong or defective actuator, same clock
    input wire logic [5:0] i_warn_cause,     // warning causes: a,b,xwire,temp,-,internal
    input wire logic [5:0] i_fault_cause,    // fault causes: a,b,xwire,temp,-,internal
    input wire logic i_comm_fail,            // gateway communication lost, same clock
    input wire logic [7:0] i_host_command_byte, // command byte from gateway
    input wire logic i_cmd_valid,            // command byte valid strobe
    input wire logic i_nv_disc_fault,        // stored discrepancy fault from nvm
    output logic o_nv_disc_fault,            // discrepancy fault to store in nvm
    output logic o_safe_out_a,               // safety output a
    output logic o_safe_out_b,               // safety output b
    output logic o_yellow,                   // yellow indicator
    output logic [7:0] o_sensor_status_byte, // status byte
    output logic [7:0] o_warning_detail_byte, // warning detail byte
    output logic [7:0] o_fault_detail_byte    // fault detail byte
);
    // ************************************************************
    // elaboration checks
    // ************************************************************
    // a zero count would leave a divider or timer stuck at its end value
    if (BLINK_HALF < 1 || DISC_LIMIT < 1 || WARN_LIMIT < 1) begin : g_chk
        $error("ssdr_core: counts must be at least one");
    end
    // the blink divider is only 32 bits wide
    if (BLINK_HALF > 64'h0000_0000_ffff_ffff) begin : g_chk_blink
        $error("ssdr_core: blink half period too long for the divider");
    end

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    localparam int NSYNC = 6;
    logic [NSYNC-1:0] pins_raw;  // raw pin vector
    logic [NSYNC-1:0] sync1_q;   // first stage, read only by second stage
    logic [NSYNC-1:0] sync2_q;   // second stage, safe to use
    assign pins_raw = {i_ack_button, i_reset_button, i_feedback_closed,
                       i_safe_in_b, i_safe_in_a, i_auto_release_variant};

    // two flops per pin
    // reset level 0 is the idle level of both button pins, so no false falling edge follows reset
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    // synced pin levels, the only readers of the second stage
    wire auto_v = sync2_q[0];   // variant strap after sync
    wire in_a = sync2_q[1];     // safety input a
    wire in_b = sync2_q[2];     // safety input b
    wire loop_c = sync2_q[3];   // feedback loop closed
    wire rst_btn = sync2_q[4];  // reset button
    wire ack_btn = sync2_q[5];  // acknowledge button

    // ************************************************************
    // edge detection
    // ************************************************************
    logic loop_q, rst_btn_q, ack_btn_q; // previous samples
    logic [7:0] cmd_q;                  // last command byte
    // previous samples; the command byte is kept only when valid
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            loop_q <= 1'b0;
            rst_btn_q <= 1'b0;
            ack_btn_q <= 1'b0;
            cmd_q <= 8'h00;
        end else begin
            loop_q <= loop_c;
            rst_btn_q <= rst_btn;
            ack_btn_q <= ack_btn;
            if (i_cmd_valid) begin
                cmd_q <= i_host_command_byte;
            end
        end
    end

    wire loop_rise = loop_c & ~loop_q;                  // contact closes
    wire rst_fall = rst_btn_q & ~rst_btn;
    wire ack_fall = ack_btn_q & ~ack_btn;
    // a command bit falls when a valid byte clears a bit that the previous byte held
    function automatic logic ssdr_bit_fell(input logic [7:0] prev, input logic [7:0] cur,
                                           input int pos);
        return prev[pos] & ~cur[pos];
    endfunction : ssdr_bit_fell

    // only bytes with the valid strobe count as command edges
    wire cmd_rst_fall = i_cmd_valid &
        ssdr_bit_fell(cmd_q, i_host_command_byte, ssdr_pkg::CMD_FAULT_RST);
    wire cmd_ack_fall = i_cmd_valid &
        ssdr_bit_fell(cmd_q, i_host_command_byte, ssdr_pkg::CMD_DISC_ACK);
    wire disc_ack = ack_fall | cmd_ack_fall;            // either path

    // ************************************************************
    // discrepancy monitoring
    // ************************************************************
    logic [63:0] disc_cnt_q;  // cycles one input low while other high
    logic disc_q;             // latched discrepancy fault
    logic nv_loaded_q;        // nvm value taken after reset
    // only a mismatch between the synced inputs is timed
    wire mismatch = i_discrepancy_enable & (in_a ^ in_b);
    wire disc_trip = mismatch && (disc_cnt_q >= 64'(DISC_LIMIT));

    // count mismatch time, latch when exceeded; set wins over acknowledge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            disc_cnt_q <= 64'h0000_0000_0000_0000;
            disc_q <= 1'b0;
            nv_loaded_q <= 1'b0;
        end else begin
            nv_loaded_q <= 1'b1;
            // restart the timer whenever the inputs agree
            if (!mismatch) begin
                disc_cnt_q <= 64'h0000_0000_0000_0000;
            end else if (!disc_trip) begin
                disc_cnt_q <= disc_cnt_q + 64'h0000_0000_0000_0001;
            end
            // first cycle after reset takes the stored fault
            if (!nv_loaded_q) begin
                disc_q <= i_nv_disc_fault;               // restore
            end else if (disc_trip) begin
                disc_q <= 1'b1;
            end else if (disc_ack) begin
                disc_q <= 1'b0;
            end
        end
    end
    // the nvm keeper stores this level across a supply loss
    assign o_nv_disc_fault = disc_q;

    // ************************************************************
    // fault and warning handling
    // ************************************************************
    logic fault_q;             // latched fault from any fault cause
    logic [63:0] warn_cnt_q;   // time warning has been active
    logic warn_to_q;           // warning timeout reached
    // a loss of the gateway link counts as a warning as well
    wire warn_any = |i_warn_cause | i_comm_fail;
    // any fault cause or an expired warning latches the fault
    wire fault_set = |i_fault_cause | i_actuator_bad | warn_to_q;

    // fault clears on bit 7 falling once cause gone; set wins
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            fault_q <= 1'b0;
        end else if (fault_set) begin
            fault_q <= 1'b1;
        end else if (cmd_rst_fall) begin
            fault_q <= 1'b0;
        end
    end

    // warning timer, trips after the limit, cleared with the warning
    always_ff @(posedge i_clk) begin
        if (i_rst || !warn_any) begin
            warn_cnt_q <= 64'h0000_0000_0000_0000;
            warn_to_q <= 1'b0;
        end else if (warn_cnt_q >= 64'(WARN_LIMIT) - 64'h0000_0000_0000_0001) begin
            warn_to_q <= 1'b1;
        end else begin
            warn_cnt_q <= warn_cnt_q + 64'h0000_0000_0000_0001;
        end
    end

    // ************************************************************
    // release state machine
    // ************************************************************
    typedef enum logic [1:0] {SSDR_OFF, SSDR_WAIT_BTN, SSDR_ON} ssdr_state_t;
    ssdr_state_t st_q, st_d;
    // a fault or discrepancy, latched or setting, forbids release and forces the outputs off
    wire blocked = fault_q | disc_q | fault_set | disc_trip;

    // next state
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            SSDR_OFF: begin
                // outputs stay off while the gateway link is down
                if (!blocked && loop_rise && !i_comm_fail) begin
                    // automatic variant needs no reset action
                    st_d = auto_v ? SSDR_ON : SSDR_WAIT_BTN;
                end
            end
            SSDR_WAIT_BTN: begin
                if (!loop_c) begin
                    // loop opened again before the button: start over
                    st_d = SSDR_OFF;
                end else if (!blocked && rst_fall && !i_comm_fail) begin
                    // release only on the button falling edge
                    st_d = SSDR_ON;
                end
            end
            SSDR_ON: begin
                if (blocked) begin
                    st_d = SSDR_OFF;
                end else if (i_comm_fail) begin
                    st_d = SSDR_ON;                      // hold state
                end else if (!(in_a & in_b)) begin
                    // inputs no longer both live
                    st_d = SSDR_OFF;
                end
            end
        endcase
    end

    // state register; powers up off
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q <= SSDR_OFF;
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // indicator blink
    // ************************************************************
    logic [31:0] blink_cnt_q;  // half period divider
    logic blink_q;             // 5 Hz square wave
    // half period divider toggles the blink square wave
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            blink_cnt_q <= 32'h0000_0000;
            blink_q <= 1'b0;
        end else if (blink_cnt_q == 32'(BLINK_HALF - 1)) begin
            blink_cnt_q <= 32'h0000_0000;
            blink_q <= ~blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
        end
    end

    // ************************************************************
    // outputs and diagnostic bytes
    // ************************************************************
    // both safety outputs follow the release state
    wire on = (st_q == SSDR_ON);
    logic [7:0] st_d_byte, wr_d_byte, ft_d_byte;
    // assemble the three diagnostic bytes from live state
    always_comb begin
        st_d_byte = 8'h00;
        st_d_byte[ssdr_pkg::ST_OUT_EN] = on;
        st_d_byte[ssdr_pkg::ST_ACT_DET] = i_actuator_detected;
        st_d_byte[ssdr_pkg::ST_LOOP_OPEN] = ~on & ~(fault_q | disc_q);
        st_d_byte[ssdr_pkg::ST_INPUTS_LIVE] = in_a & in_b;
        st_d_byte[ssdr_pkg::ST_LIMIT] = i_limit_area;
        st_d_byte[ssdr_pkg::ST_WARN] = warn_any | fault_q | disc_q;
        st_d_byte[ssdr_pkg::ST_FAULT] = fault_q | disc_q;
        wr_d_byte = {1'b0, i_comm_fail, i_warn_cause};
        wr_d_byte[ssdr_pkg::DT_ACTUATOR] = 1'b0;
        ft_d_byte = {1'b0, disc_q, i_fault_cause};
        ft_d_byte[ssdr_pkg::DT_ACTUATOR] = i_actuator_bad;
    end

    // every output is registered so the pins never see decode glitches
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_safe_out_a <= 1'b0;
            o_safe_out_b <= 1'b0;
            o_yellow <= 1'b0;
            o_sensor_status_byte <= 8'h00;
            o_warning_detail_byte <= 8'h00;
            o_fault_detail_byte <= 8'h00;
        end else begin
            o_safe_out_a <= on;
            o_safe_out_b <= on;
            o_yellow <= on ? 1'b1 : blink_q;
            o_sensor_status_byte <= st_d_byte;
            o_warning_detail_byte <= wr_d_byte;
            o_fault_detail_byte <= ft_d_byte;
        end
    end
endmodule : ssdr_core

// ---- verif/ssdr_chk.sv ----
module ssdr_chk #(
    parameter longint DISC_LIMIT = 20, // discrepancy limit cycles
    parameter longint WARN_LIMIT = 30 // warning timeout cycles
) (
    input wire logic i_clk, // system clock
    input wire logic i_rst, // synchronous reset
    input wire logic i_auto_release_variant, // release strap
    input wire logic i_discrepancy_enable, // monitor strap
    input wire logic i_safe_in_a, // input a pin
    input wire logic i_safe_in_b, // input b pin
    input wire logic i_feedback_closed, // loop pin
    input wire logic i_reset_button, // reset button pin
    input wire logic i_actuator_detected, // actuator level
    input wire logic i_comm_fail, // gateway lost
    input wire logic [5:0] i_warn_cause, // warning causes
    input wire logic o_nv_disc_fault, // stored fault
    input wire logic o_safe_out_a, // output a
    input wire logic o_safe_out_b, // output b
    input wire logic [7:0] o_sensor_status_byte, // status byte
    input wire logic [7:0] o_warning_detail_byte // warning byte
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ************************************
    // helper counters
    // ************************************
    int mm_q; // cycles with inputs apart
    int wn_q; // cycles with a warning cause
    int age_q; // cycles since button release
    logic btn_q; // last button level
    wire on2 = o_safe_out_a && o_safe_out_b; // both outputs on
    wire off2 = !o_safe_out_a && !o_safe_out_b; // both outputs off
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mm_q <= 0;
            wn_q <= 0;
            age_q <= 255;
            btn_q <= 1'b0;
        end else begin
            mm_q <= (i_discrepancy_enable && i_safe_in_a != i_safe_in_b) ? mm_q + 1 : 0;
            wn_q <= ((i_warn_cause & 6'h2f) != 6'h00) ? wn_q + 1 : 0;
            age_q <= (btn_q && !i_reset_button) ? 0 : ((age_q < 255) ? age_q + 1 : 255);
            btn_q <= i_reset_button;
        end
    end
    // ************************************
    // assertions
    // ************************************
    sequence s_close;
        i_auto_release_variant && !i_comm_fail && $rose(i_feedback_closed)
            && i_safe_in_a && i_safe_in_b;
    endsequence
    sequence s_clean;
        i_actuator_detected && !o_sensor_status_byte[7] && !o_nv_disc_fault;
    endsequence
    a_power_up_off: assert property ($fell(i_rst) |-> off2[*3])
        else $error("outputs on right after reset");
    a_auto_release: assert property (s_close ##0 s_clean |-> ##[3:6] on2)
        else $error("closing loop did not release");
    a_button_only: assert property (!i_auto_release_variant && $rose(o_safe_out_a)
        |-> age_q < 8)
        else $error("release without button edge");
    a_disc_trip: assert property (mm_q > DISC_LIMIT + 8 |-> off2)
        else $error("outputs on after discrepancy");
    a_warn_timeout: assert property (wn_q > WARN_LIMIT + 8 |-> off2)
        else $error("outputs on after warning timeout");
    a_comm_hold: assert property (i_comm_fail[*5] |-> $stable(o_safe_out_a)
        && $stable(o_safe_out_b))
        else $error("outputs moved during comm loss");
    a_warn_temp: assert property (i_warn_cause[3][*4] |-> o_warning_detail_byte[3])
        else $error("temperature warning bit missing");
    a_act_bit: assert property (i_actuator_detected[*4] |-> o_sensor_status_byte[1])
        else $error("actuator status bit missing");
    a_disc_block: assert property (o_nv_disc_fault |=> off2)
        else $error("outputs on while discrepancy pending");
    a_fault_off: assert property (o_sensor_status_byte[7] |-> off2)
        else $error("outputs on while fault reported");
endmodule : ssdr_chk

bind ssdr_core ssdr_chk #(.DISC_LIMIT(DISC_LIMIT), .WARN_LIMIT(WARN_LIMIT)) u_ssdr_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_auto_release_variant(i_auto_release_variant),
    .i_discrepancy_enable(i_discrepancy_enable), .i_safe_in_a(i_safe_in_a),
    .i_safe_in_b(i_safe_in_b), .i_feedback_closed(i_feedback_closed),
    .i_reset_button(i_reset_button), .i_actuator_detected(i_actuator_detected),
    .i_comm_fail(i_comm_fail), .i_warn_cause(i_warn_cause), .o_nv_disc_fault(o_nv_disc_fault),
    .o_safe_out_a(o_safe_out_a), .o_safe_out_b(o_safe_out_b),
    .o_sensor_status_byte(o_sensor_status_byte), .o_warning_detail_byte(o_warning_detail_byte));

// ---- verif/ssdr_gateway.sv ----
module ssdr_gateway (
    input wire logic i_clk, // system clock
    input wire logic i_send, // bench asks for one byte
    input wire logic [7:0] i_byte, // byte to send
    output logic [7:0] o_host_command_byte, // command byte to sensor
    output logic o_cmd_valid // one-cycle strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last_q = 8'h00; // last byte sent
    // a 1 then 0 in bit 7 or 6 of two sent bytes clears a fault
    always_ff @(posedge i_clk) begin
        o_cmd_valid <= i_send;
        o_host_command_byte <= i_send ? i_byte : ~last_q; // idle lines carry the inverse of the last byte
        if (i_send) begin
            last_q <= i_byte;
        end
    end
endmodule : ssdr_gateway

// ---- verif/ssdr_core_tb_top.sv ----
module ssdr_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {int k; logic [7:0] e;} ssdr_note_t;
    localparam int BH = 4; // short blink half period
    localparam int DL = 20; // short discrepancy limit
    localparam int WL = 30; // short warning timeout
    logic i_clk = 0, i_rst = 1, av = 1, den = 0, ia = 1, ib = 1, fb = 0, rb = 0, ab = 0;
    logic act = 1, lim = 0, bad = 0, cf = 0, nvi = 0, gs = 0, cv, nvo, sa, sb, yel;
    logic [5:0] wc = 0, fc = 0;
    logic [7:0] gb = 0, cmd, st, wd, fd;
    int error_cnt = 0, n_tests = 0, seed = 10;
    ssdr_note_t q[$], nt;
    always #2 i_clk = ~i_clk;
    ssdr_gateway u_ssdr_gateway (.i_clk(i_clk), .i_send(gs), .i_byte(gb),
        .o_host_command_byte(cmd), .o_cmd_valid(cv));
    ssdr_core #(.BLINK_HALF(BH), .DISC_LIMIT(DL), .WARN_LIMIT(WL)) u_ssdr_core (
        .i_clk(i_clk), .i_rst(i_rst), .i_auto_release_variant(av), .i_discrepancy_enable(den),
        .i_safe_in_a(ia), .i_safe_in_b(ib), .i_feedback_closed(fb), .i_reset_button(rb),
        .i_ack_button(ab), .i_actuator_detected(act), .i_limit_area(lim), .i_actuator_bad(bad),
        .i_warn_cause(wc), .i_fault_cause(fc), .i_comm_fail(cf), .i_host_command_byte(cmd),
        .i_cmd_valid(cv), .i_nv_disc_fault(nvi), .o_nv_disc_fault(nvo), .o_safe_out_a(sa),
        .o_safe_out_b(sb), .o_yellow(yel), .o_sensor_status_byte(st),
        .o_warning_detail_byte(wd), .o_fault_detail_byte(fd));
    // ************************************
    // tasks
    // ************************************
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : step
    task automatic note(input int k, input logic [7:0] e);
        q.push_back('{k, e});
    endtask : note
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic send(input logic [7:0] b);
        gs = 1;
        gb = b;
        step(1);
        gs = 0;
        step(3);
    endtask : send
    task automatic do_reset(input logic v, input logic nv);
        i_rst = 1;
        av = v;
        nvi = nv;
        fb = 0;
        step(4);
        i_rst = 0;
        step(10);
    endtask : do_reset
    task automatic reclose();
        fb = 0;
        step(6);
        fb = 1;
        step(8);
    endtask : reclose
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    // every queued note is checked, oldest first, against the settled outputs
    always @(negedge i_clk) begin
        while (q.size() > 0) begin
            nt = q.pop_front();
            case (nt.k)
                0: cmp("outputs", nt.e, {6'h00, sa, sb});
                1: cmp("status", nt.e, st & 8'hf7);
                2: cmp("warning detail", nt.e, wd);
                4: cmp("stored fault", nt.e, {7'h00, nvo});
                5: cmp("yellow", nt.e, {7'h00, yel});
                default: cmp("fault detail", nt.e, fd);
            endcase
        end
    end
    // run needs under 1000 cycles, so 20 us means a hang
    initial begin
        #20000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        logic [5:0] w;
        logic y_prev;
        int tg;
        do_reset(1, 0);
        note(0, 8'h00);
        note(1, 8'h12);
        // four half periods of the blink hold exactly four toggles
        y_prev = yel;
        tg = 0;
        repeat (4 * BH) begin
            step(1);
            tg += int'(yel != y_prev);
            y_prev = yel;
        end
        cmp("yellow toggles", 8'h04, 8'(tg));
        fb = 1;
        step(8);
        note(0, 8'h03);
        note(5, 8'h01);
        lim = 1;
        step(6);
        note(1, 8'h33);
        lim = 0;
        w = 6'($random(seed)) & 6'h2f | 6'h08;
        wc = w;
        step(6);
        note(2, {2'b00, w[5], 1'b0, w[3:0]});
        note(1, 8'h53);
        step(WL + 4);
        note(0, 8'h00);
        wc = 0;
        send(8'h80);
        send(8'h00);
        step(4);
        note(1, 8'h12);
        reclose();
        w = 6'($random(seed)) & 6'h2f;
        fc = w;
        bad = 1;
        step(6);
        note(3, {2'b00, w[5], 1'b1, w[3:0]});
        fc = 0;
        bad = 0;
        send(8'h80);
        send(8'h00);
        reclose();
        cf = 1;
        step(2);
        ia = 0;
        ib = 0;
        step(8);
        note(0, 8'h03);
        note(2, 8'h40);
        ia = 1;
        ib = 1;
        step(4);
        cf = 0;
        den = 1;
        step(4);
        ia = 0;
        step(DL + 10);
        note(0, 8'h00);
        note(3, 8'h40);
        ib = 0;
        step(4);
        ia = 1;
        ib = 1;
        reclose();
        note(0, 8'h00);
        send(8'h40);
        send(8'h00);
        note(3, 8'h00);
        reclose();
        note(0, 8'h03);
        ib = 0;
        step(DL + 10);
        ia = 0;
        step(4);
        ia = 1;
        ib = 1;
        note(4, 8'h01);
        do_reset(1, nvo);
        note(3, 8'h40);
        note(4, 8'h01);
        fb = 1;
        step(8);
        note(0, 8'h00);
        ab = 1;
        step(4);
        ab = 0;
        step(6);
        note(3, 8'h00);
        note(4, 8'h00);
        do_reset(0, 0);
        fb = 1;
        step(8);
        note(0, 8'h00);
        rb = 1;
        step(6);
        note(0, 8'h00);
        rb = 0;
        step(8);
        note(0, 8'h03);
        step(2);
        wrap_up();
    end
endmodule : ssdr_core_tb_top
